// File: include/addr_high_io_pkg.sv
// constants for the upper-address-byte i/o port
// assumes a 32-bit avalon-mm register bus with word addresses in bytes
package addr_high_io_pkg;
    // register indices; the byte address is four times the index
    localparam logic [15:0] IDX_PULLUP = 16'hffad;
    localparam logic [15:0] IDX_DIR = 16'hffb1;
    localparam logic [15:0] IDX_LATCH = 16'hffb3;
    localparam logic [17:0] ADR_PULLUP = {IDX_PULLUP, 2'b00};
    localparam logic [17:0] ADR_DIR = {IDX_DIR, 2'b00};
    localparam logic [17:0] ADR_LATCH = {IDX_LATCH, 2'b00};
    localparam int ADDR_W = 18;
    localparam int PORT_W = 8;
    // reset values
    localparam logic [7:0] RST_ZERO = 8'h00;
    localparam logic [7:0] DIR_MODE1 = 8'hff;
    // operating mode codes
    localparam logic [1:0] MODE_EXP_NOROM = 2'h1;
    localparam logic [1:0] MODE_EXP_ROM = 2'h2;
    localparam logic [1:0] MODE_SINGLE = 2'h3;
    // bus answer state machine
    typedef enum logic [1:0] {
        BUS_IDLE = 2'b00,
        BUS_DONE = 2'b01
    } bus_state_t;
endpackage

// File: verilog/addr_high_io_port.sv
// upper address byte / general purpose i/o port with avalon-mm registers
// assumes mode pins and standby inputs are asynchronous levels from the chip
// Operation
// - direction bit one means output pin
// - data read: latch for outputs, pin otherwise
// - pull-up on when enabled and input
// - mode 1: address out, direction forced ones
// - mode 2: input or address per bit
// - mode 3: plain general-purpose i/o
// - reset clears all three registers
// - mode 1 direction set to 0xff once mode 1 is seen after reset
// - hardware standby: tristate, clear registers except mode 1 direction
// - software standby: hold, address pins low
// - pull-ups only in modes 2, 3
//
// The Avalon-MM slave port was left to the implementer.
`timescale 1ns/1ns
module addr_high_io_port
    import addr_high_io_pkg::*;
(
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire logic [1:0] mode_sel,
    input wire logic hw_standby,
    input wire logic sw_standby,
    input wire logic [7:0] addr_high,
    input wire logic [ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic [7:0] pin_in,
    output logic [7:0] pin_out,
    output logic [7:0] pin_oe,
    output logic [7:0] pin_pullup
);

    logic [1:0] mode_s1_r;
    logic [1:0] mode_r;
    logic hws_s1_r;
    logic hws_r;
    logic sws_s1_r;
    logic sws_r;
    logic [7:0] pin_s1_r;
    logic [7:0] pin_r;
    logic rst_done_r;
    logic [7:0] pin_direction_select_r;
    logic [7:0] pin_output_latch_r;
    logic [7:0] pin_pullup_enable_r;
    bus_state_t bus_state_r;
    logic req;
    logic wr_take;
    logic mode1;
    logic [7:0] addr_use;
    logic [7:0] pin_out_nxt;
    logic [7:0] pin_oe_nxt;
    logic [7:0] pin_pullup_nxt;
    logic [7:0] read_port;
    logic [31:0] rdata_nxt;
    logic take;
    logic wr_dir;
    logic wr_latch;
    logic wr_pullup;

    // mode pins: two-stage synchroniser
    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            mode_s1_r <= MODE_SINGLE;
            mode_r <= MODE_SINGLE;
        end
        else if (clk_en)
        begin
            mode_s1_r <= mode_sel;
            mode_r <= mode_s1_r;
        end
    end

    // hardware standby level: two-stage synchroniser
    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            hws_s1_r <= 1'b0;
            hws_r <= 1'b0;
        end
        else if (clk_en)
        begin
            hws_s1_r <= hw_standby;
            hws_r <= hws_s1_r;
        end
    end

    // software standby level: two-stage synchroniser
    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            sws_s1_r <= 1'b0;
            sws_r <= 1'b0;
        end
        else if (clk_en)
        begin
            sws_s1_r <= sw_standby;
            sws_r <= sws_s1_r;
        end
    end

    // pin levels: two-stage synchroniser, first stage read only here
    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            pin_s1_r <= RST_ZERO;
            pin_r <= RST_ZERO;
        end
        else if (clk_en)
        begin
            pin_s1_r <= pin_in;
            pin_r <= pin_s1_r;
        end
    end

    assign mode1 = (mode_r == MODE_EXP_NOROM);
    assign req = avs_read | avs_write;
    // a write lands on the answering edge only
    assign wr_take = avs_write && (bus_state_r == BUS_DONE) && avs_byteenable[0];
    // a request is taken while the answer machine is idle
    assign take = req && (bus_state_r == BUS_IDLE);
    // direction writes ignored in mode 1
    assign wr_dir = wr_take && (avs_address == ADR_DIR) && !mode1;
    // write strobes for the other two registers
    assign wr_latch = wr_take && (avs_address == ADR_LATCH);
    assign wr_pullup = wr_take && (avs_address == ADR_PULLUP);

    // goes high on the first enabled edge after reset release and stays high
    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
            rst_done_r <= 1'b0;
        else if (clk_en)
            rst_done_r <= 1'b1;
    end

    // direction register
    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
            pin_direction_select_r <= RST_ZERO;
        else if (clk_en)
        begin
            if (mode1 && rst_done_r)
                pin_direction_select_r <= DIR_MODE1;
            else if (hws_r)
                pin_direction_select_r <= RST_ZERO;
            else if (wr_dir)
                pin_direction_select_r <= avs_writedata[7:0];
        end
    end

    // data latch register
    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
            pin_output_latch_r <= RST_ZERO;
        else if (clk_en)
        begin
            if (hws_r)
                pin_output_latch_r <= RST_ZERO;
            else if (wr_latch)
                pin_output_latch_r <= avs_writedata[7:0];
        end
    end

    // pull-up enable register
    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
            pin_pullup_enable_r <= RST_ZERO;
        else if (clk_en)
        begin
            if (hws_r)
                pin_pullup_enable_r <= RST_ZERO;
            else if (wr_pullup)
                pin_pullup_enable_r <= avs_writedata[7:0];
        end
    end

    assign addr_use = sws_r ? RST_ZERO : addr_high;

    // per-pin drive, enable and pull-up
    genvar gi;
    generate
        for (gi = 0; gi < PORT_W; gi++)
        begin : g_pin
            always_comb
            begin
                pin_out_nxt[gi] = 1'b0;
                pin_oe_nxt[gi] = 1'b0;
                pin_pullup_nxt[gi] = 1'b0;
                if (hws_r)
                begin
                    pin_oe_nxt[gi] = 1'b0;
                end
                else
                begin
                    case (mode_r)
                        MODE_EXP_NOROM:
                        begin
                            pin_oe_nxt[gi] = 1'b1;
                            pin_out_nxt[gi] = addr_use[gi];
                        end
                        MODE_EXP_ROM:
                        begin
                            pin_oe_nxt[gi] = pin_direction_select_r[gi];
                            pin_out_nxt[gi] = addr_use[gi];
                        end
                        default:
                        begin
                            pin_oe_nxt[gi] = pin_direction_select_r[gi];
                            pin_out_nxt[gi] = pin_output_latch_r[gi];
                        end
                    endcase
                    pin_pullup_nxt[gi] = !mode1 && pin_pullup_enable_r[gi]
                        && !pin_direction_select_r[gi];
                end
            end
        end
    endgenerate

    // registered pin drive value
    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
            pin_out <= RST_ZERO;
        else if (clk_en)
            pin_out <= pin_out_nxt;
    end

    // registered output enables, all off in reset
    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
            pin_oe <= RST_ZERO;
        else if (clk_en)
            pin_oe <= pin_oe_nxt;
    end

    // registered pull-up controls, all off in reset
    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
            pin_pullup <= RST_ZERO;
        else if (clk_en)
            pin_pullup <= pin_pullup_nxt;
    end

    // latch for outputs, pin for inputs
    assign read_port = (pin_direction_select_r & pin_output_latch_r)
        | (~pin_direction_select_r & pin_r);

    // read mux; direction reads zero, unmapped reads zero
    always_comb
    begin
        rdata_nxt = 32'h0000_0000;
        case (avs_address)
            ADR_LATCH:
                rdata_nxt = {24'h00_0000, read_port};
            ADR_PULLUP:
                rdata_nxt = {24'h00_0000, pin_pullup_enable_r};
            default:
                rdata_nxt = 32'h0000_0000;
        endcase
    end

    // read data captured as the request is taken
    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
            avs_readdata <= 32'h0000_0000;
        else if (clk_en && take)
            avs_readdata <= rdata_nxt;
    end

    // waitrequest drops for the answer cycle only
    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
            avs_waitrequest <= 1'b1;
        else if (clk_en)
        begin
            if (take)
                avs_waitrequest <= 1'b0;
            else
                avs_waitrequest <= 1'b1;
        end
    end

    // bus answer state: one idle cycle between answers
    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
            bus_state_r <= BUS_IDLE;
        else if (clk_en)
        begin
            case (bus_state_r)
                BUS_IDLE:
                begin
                    if (req)
                        bus_state_r <= BUS_DONE;
                end
                BUS_DONE:
                begin
                    bus_state_r <= BUS_IDLE;
                end
                default:
                begin
                    bus_state_r <= BUS_IDLE;
                end
            endcase
        end
    end

endmodule

// File: verification/addr_high_io_port_assertions.sv
// checker for the upper address port, bound to its top module
// assumes clk_en stays high while it watches
`timescale 1ns/1ns
module addr_high_io_port_assertions
    import addr_high_io_pkg::*;
(
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic [1:0] mode_sel,
    input wire logic hw_standby,
    input wire logic sw_standby,
    input wire logic [7:0] addr_high,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic avs_waitrequest,
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pin_oe,
    input wire logic [7:0] pin_pullup
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    // bus answer and its single-cycle pulse
    bus_answer_a: assert property ((avs_read || avs_write) && avs_waitrequest
        |-> ##[1:2] !avs_waitrequest) else $error("bus request not answered");
    wait_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("answer longer than one cycle");
    // pin state per mode and standby
    pull_in_a:
        assert property ((pin_pullup & pin_oe) == '0) else $error("pull-up on output");
    hw_off_a:
        assert property (hw_standby [*4] |-> pin_oe == '0 && pin_pullup == '0)
        else $error("pins active in hardware standby");
    mode1_addr_a:
        assert property ((mode_sel == MODE_EXP_NOROM && !hw_standby && !sw_standby) [*6]
        |-> pin_oe == 8'hff && pin_out == $past(addr_high)) else $error("mode 1 address");
    mode1_pull_a:
        assert property ((mode_sel == MODE_EXP_NOROM) [*6] |-> pin_pullup == '0)
        else $error("pull-up on in mode 1");
    mode2_addr_a:
        assert property ((mode_sel == MODE_EXP_ROM && !hw_standby && !sw_standby) [*6]
        |-> (pin_out & pin_oe) == ($past(addr_high) & pin_oe)) else $error("mode 2 address");
    sw_low_a:
        assert property ((mode_sel == MODE_EXP_ROM && sw_standby && !hw_standby) [*6]
        |-> (pin_out & pin_oe) == '0) else $error("address pins not low in standby");
endmodule
bind addr_high_io_port addr_high_io_port_assertions addr_high_io_port_assertions_inst (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .mode_sel(mode_sel), .hw_standby(hw_standby),
    .sw_standby(sw_standby), .addr_high(addr_high), .avs_read(avs_read),
    .avs_write(avs_write), .avs_waitrequest(avs_waitrequest), .pin_out(pin_out),
    .pin_oe(pin_oe), .pin_pullup(pin_pullup));

// File: verification/pin_load_model.sv
// external load on the port pins: a driver, pull-ups and floating lines
// assumes the port drive wins over the external driver
`timescale 1ns/1ns
module pin_load_model (
    input wire logic ref_clk,
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pin_oe,
    input wire logic [7:0] pin_pullup,
    input wire logic [7:0] ext_val,
    input wire logic ext_en,
    output logic [7:0] pin_lvl
);
    logic flt_r = 1'b0;
    // a floating line changes every cycle
    always @(posedge ref_clk)
        flt_r <= ~flt_r;
    // port drive, then external drive, then pull-up
    assign pin_lvl = (pin_oe & pin_out)
        | (~pin_oe & (ext_en ? ext_val : pin_pullup | {8{flt_r}}));
endmodule

// File: verification/tb_addr_high_io_port.sv
// self-checking bench for the upper address port
// assumes the register map and bus timing of the package
`timescale 1ns/1ns
module tb_addr_high_io_port
    import addr_high_io_pkg::*;
;
    logic ref_clk = 0, sys_rst = 1, clk_en = 1, hw_standby = 0, sw_standby = 0;
    logic avs_read = 0, avs_write = 0, avs_waitrequest, ext_en = 1;
    logic [1:0] mode_sel = MODE_SINGLE;
    logic [7:0] addr_high = 8'h96, ext_val = 8'ha5, pin_in, pin_out, pin_oe, pin_pullup, rdat;
    logic [3:0] avs_byteenable = 4'h1;
    logic [ADDR_W-1:0] avs_address = '0;
    logic [31:0] avs_writedata = '0, avs_readdata;
    int error_cnt = 0, checked = 0;
    addr_high_io_port addr_high_io_port_inst (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .clk_en(clk_en), .mode_sel(mode_sel), .hw_standby(hw_standby),
        .sw_standby(sw_standby), .addr_high(addr_high), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_byteenable(avs_byteenable),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .pin_in(pin_in), .pin_out(pin_out),
        .pin_oe(pin_oe), .pin_pullup(pin_pullup));
    pin_load_model pin_load_model_inst (.ref_clk(ref_clk), .pin_out(pin_out),
        .pin_oe(pin_oe), .pin_pullup(pin_pullup), .ext_val(ext_val), .ext_en(ext_en),
        .pin_lvl(pin_in));
    // 25 MHz clock
    always #20 ref_clk = ~ref_clk;
    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        checked++;
        if (s !== e)
        begin
            error_cnt++;
            $display("unexpected %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic give_verdict();
        if (error_cnt == 0 && checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // one bus cycle, held until waitrequest is seen low
    task automatic xfer(input logic w, input logic [ADDR_W-1:0] a, input logic [7:0] d);
        int n;
        n = 0;
        avs_address <= a;
        avs_writedata <= {24'h00_0000, d};
        avs_write <= w;
        avs_read <= !w;
        do
        begin
            @(posedge ref_clk);
            n++;
        end
        while (avs_waitrequest !== 1'b0 && n < 50);
        rdat = avs_readdata[7:0];
        avs_write <= 0;
        avs_read <= 0;
        if (n == 50)
        begin
            error_cnt++;
            disable main_seq;
        end
        @(posedge ref_clk);
    endtask
    task automatic rd(input string nm, input logic [ADDR_W-1:0] a, input logic [7:0] e);
        xfer(0, a, 8'h00);
        chk(nm, rdat, e);
    endtask
    // main sequence; a bus timeout leaves it early
    initial
    begin
        begin : main_seq
            repeat (4) @(posedge ref_clk);
            sys_rst <= 0;
            repeat (4) @(posedge ref_clk);
            rd("pullup", ADR_PULLUP, RST_ZERO);
            rd("dir", ADR_DIR, RST_ZERO);
            rd("latch", ADR_LATCH, 8'ha5);
            rd("unmapped", '0, 8'h00);
            xfer(1, ADR_PULLUP, 8'h0f);
            xfer(1, ADR_DIR, 8'h3c);
            xfer(1, ADR_LATCH, 8'h5a);
            avs_byteenable <= 4'h0;
            xfer(1, ADR_LATCH, 8'hff);
            avs_byteenable <= 4'h1;
            repeat (4) @(posedge ref_clk);
            chk("pin_oe", pin_oe, 8'h3c);
            chk("pin_pullup", pin_pullup, 8'h0f & ~8'h3c);
            chk("pin_out", pin_out & pin_oe, 8'h5a & 8'h3c);
            rd("latch", ADR_LATCH, (8'h5a & 8'h3c) | (8'ha5 & ~8'h3c));
            rd("pullup", ADR_PULLUP, 8'h0f);
            // clock enable low: standby request must not reach the pins
            clk_en <= 0;
            hw_standby <= 1;
            repeat (3) @(posedge ref_clk);
            chk("pin_oe", pin_oe, 8'h3c);
            chk("pin_pullup", pin_pullup, 8'h03);
            hw_standby <= 0;
            clk_en <= 1;
            repeat (2) @(posedge ref_clk);
            sw_standby <= 1;
            repeat (4) @(posedge ref_clk);
            chk("pin_out", pin_out & pin_oe, 8'h5a & 8'h3c);
            chk("pin_pullup", pin_pullup, 8'h03);
            sw_standby <= 0;
            mode_sel <= MODE_EXP_ROM;
            repeat (6) @(posedge ref_clk);
            chk("pin_out", pin_out & pin_oe, 8'h96 & 8'h3c);
            chk("pin_pullup", pin_pullup, 8'h03);
            // external driver off: pulled inputs read high
            ext_en <= 0;
            repeat (3) @(posedge ref_clk);
            xfer(0, ADR_LATCH, 8'h00);
            chk("latch_pullup", rdat & 8'h3f, 8'h1b);
            ext_en <= 1;
            sw_standby <= 1;
            repeat (6) @(posedge ref_clk);
            chk("pin_out", pin_out & pin_oe, 8'h00);
            chk("pin_oe", pin_oe, 8'h3c);
            sw_standby <= 0;
            hw_standby <= 1;
            repeat (4) @(posedge ref_clk);
            chk("pin_oe", pin_oe, 8'h00);
            chk("pin_pullup", pin_pullup, 8'h00);
            hw_standby <= 0;
            repeat (4) @(posedge ref_clk);
            rd("pullup", ADR_PULLUP, 8'h00);
            rd("latch", ADR_LATCH, 8'ha5);
            mode_sel <= MODE_EXP_NOROM;
            sys_rst <= 1;
            repeat (4) @(posedge ref_clk);
            sys_rst <= 0;
            repeat (6) @(posedge ref_clk);
            chk("pin_oe", pin_oe, DIR_MODE1);
            chk("pin_out", pin_out, 8'h96);
            xfer(1, ADR_DIR, 8'h00);
            xfer(1, ADR_PULLUP, 8'hff);
            repeat (2) @(posedge ref_clk);
            chk("pin_oe", pin_oe, 8'hff);
            chk("pin_pullup", pin_pullup, 8'h00);
            rd("pullup", ADR_PULLUP, 8'hff);
        end
        give_verdict();
    end
endmodule
